// ---- aessc_ctrl.sv ----
// encoder control: serial position link, zero-set, direction, fault status
// Operation
// - indicator off normally, on for any fault
// - fault latched in SSI mode until power-off
// - clock restart within monoflop repeats same data
// - clock restart after monoflop sends fresh data
// - position width is 10 to 14 or 17
// - BiSS frame carries parameters and CRC
// - zero-set makes current position zero or preset
// - zero-set acts after about 1 ms delay
// - 15 ms processing after zero-set, indicator on
// - zero-set complete after 14 ms timeout
// - direction input high reverses count sense
// - direction change while powered is an error
// - direction change applies within 1 ms
// - position valid only after 150 ms power-on
//
// Decided for this implementation: the plain strobed port and the address map.
module aessc_ctrl #(
  parameter int SET_DLY  = aessc_pkg::SET_DLY_CYC,
  parameter int SET_TMO  = aessc_pkg::SET_TMO_CYC,
  parameter int SET_PROC = aessc_pkg::SET_PROC_CYC,
  parameter int PWR_ON   = aessc_pkg::PWR_ON_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire aessc_pkg::aessc_reg_req_t reg_req,
  output logic [31:0]                 reg_rdata,
  input  wire logic [16:0]            position_in,
  input  wire aessc_pkg::aessc_fault_t   fault_in,
  input  wire logic                   link_clk,
  output logic                        ser_data,
  output logic                        ser_data_oe,
  input  wire logic                   zero_set_pin,
  input  wire logic                   zero_set_btn,
  input  wire logic                   dir_pin,
  output logic                        count_reverse,
  output logic                        led_on,
  output logic                        status_n
);
  import aessc_pkg::*;

  typedef struct packed {
    aessc_frame_t      fr;
    logic [31:0]       shadow;
    logic [4:0]        len;
    logic [31:0]       shift;
    logic [4:0]        bits;
    logic [CNT_W-1:0]  mono;
    aessc_zs_t         zs;
    logic [CNT_W-1:0]  zcnt;
    logic              done;
    logic [POS_W-1:0]  offset;
    logic [CNT_W-1:0]  pu;
    logic              ready;
    logic              dir_ref;
    logic              err;
    logic              biss;
    logic              gray;
    logic              dirinv;
    logic [4:0]        res;
    logic [POS_W-1:0]  preset;
    logic [31:0]       rdata;
    logic              ser;
    logic              oe;
    logic              rev;
    logic              led;
    logic              stat_n;
  } aessc_state_t;

  aessc_state_t r;
  aessc_state_t next_r;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;

  assign pin_raw = {dir_pin, zero_set_btn, zero_set_pin, link_clk};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_sync
      aessc_pin_sync #(
        .RST_LVL (PIN_RST_LVL[gi])
      ) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (pin_raw[gi]),
        .level    (pin_lvl[gi]),
        .rise     (pin_rise[gi]),
        .fall     (pin_fall[gi])
      );
    end
  endgenerate

  function automatic logic res_ok(input logic [4:0] res);
    res_ok = (res >= 5'h0A && res <= 5'h0E) || res == 5'h11;
  endfunction

  function automatic logic [POS_W-1:0] res_mask(input logic [4:0] res);
    res_mask = POS_W'((32'h1 << res) - 32'h1);
  endfunction

  function automatic logic [5:0] crc6(input logic [18:0] d);
    logic [5:0] c;
    logic       fb;
    c = 6'h00;
    for (int i = 18; i >= 0; i--)
    begin
      fb = c[5] ^ d[i];
      c  = {c[4:0], 1'b0};
      if (fb)
        c = c ^ CRC_POLY;
    end
    crc6 = c;
  endfunction

  // fresh position word, built every cycle
  logic [POS_W-1:0] mask;
  logic [POS_W-1:0] raw;
  logic [POS_W-1:0] adj;
  logic [POS_W-1:0] cur;
  logic [POS_W-1:0] coded;
  logic             warn_n;
  logic             err_n;
  logic [5:0]       crc;
  logic [31:0]      fresh;
  logic [4:0]       fresh_len;
  logic             rev_now;
  logic             fault_ev;
  logic             set_lvl;

  always_comb
  begin
    mask    = res_mask(r.res);
    rev_now = pin_lvl[PIN_DIR] ^ r.dirinv;
    raw     = position_in & mask;
    adj     = rev_now ? (mask - raw) : raw;
    cur     = (adj - r.offset) & mask;
    coded   = (r.gray && !r.biss) ? (cur ^ (cur >> 1)) : cur;
    err_n   = ~r.err;
    warn_n  = ~(r.zs == ZS_BUSY);
    crc     = crc6({coded, err_n, warn_n});
    if (r.biss)
    begin
      // start, control bit, position, error, warning, inverted crc
      fresh_len = r.res + BISS_XTRA;
      fresh     = ((32'h2 << (r.res + 5'h08))
                  | (32'(coded) << 8)
                  | (32'({err_n, warn_n}) << 6)
                  | {26'h0, ~crc}) << (6'h20 - 6'(fresh_len));
    end
    else
    begin
      fresh_len = r.res;
      fresh     = 32'(coded) << (6'h20 - 6'(r.res));
    end
    fault_ev = fault_in.sensor | fault_in.led | fault_in.temp
             | (r.ready & (pin_lvl[PIN_DIR] != r.dir_ref));
    set_lvl  = pin_lvl[PIN_SET] | pin_lvl[PIN_BTN];
  end

  always_comb
  begin
    next_r       = r;
    next_r.rdata = 32'h0;

    // register port
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        REG_CTRL:
        begin
          next_r.biss   = reg_req.wdata[CTRL_BISS];
          next_r.gray   = reg_req.wdata[CTRL_GRAY];
          next_r.dirinv = reg_req.wdata[CTRL_DIRINV];
          if (res_ok(reg_req.wdata[CTRL_RES_LSB +: 5]))
            next_r.res = reg_req.wdata[CTRL_RES_LSB +: 5];
        end
        REG_PRESET: next_r.preset = reg_req.wdata[POS_W-1:0];
        default: ;
      endcase
    end
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        REG_CTRL:
          next_r.rdata = (32'(r.res) << CTRL_RES_LSB)
                       | (32'(r.dirinv) << CTRL_DIRINV)
                       | (32'(r.gray) << CTRL_GRAY)
                       | (32'(r.biss) << CTRL_BISS);
        REG_PRESET: next_r.rdata = 32'(r.preset);
        REG_STATUS:
          next_r.rdata = (32'(r.fr != FR_IDLE) << ST_FRAME)
                       | (32'(r.rev) << ST_REV)
                       | (32'(r.done) << ST_DONE)
                       | (32'(r.zs == ZS_BUSY) << ST_BUSY)
                       | (32'(r.ready) << ST_READY)
                       | (32'(r.err) << ST_ERR);
        default: next_r.rdata = 32'h0;
      endcase
    end

    // power-on wait, direction reference caught at its end
    if (!r.ready)
    begin
      next_r.pu = r.pu + 1'b1;
      if (r.pu == CNT_W'(PWR_ON - 1))
      begin
        next_r.ready   = 1'b1;
        next_r.dir_ref = pin_lvl[PIN_DIR];
      end
    end

    // fault latch: only a BiSS clear command may drop it; set wins
    if (r.biss && reg_req.wr && reg_req.addr == REG_CTRL
        && reg_req.wdata[CTRL_ERRCLR])
    begin
      next_r.err     = 1'b0;
      next_r.dir_ref = pin_lvl[PIN_DIR];
    end
    if (fault_ev)
      next_r.err = 1'b1;

    // zero-set sequence
    case (r.zs)
      ZS_IDLE:
      begin
        next_r.zcnt = '0;
        if (set_lvl)
          next_r.zs = ZS_DELAY;
      end
      ZS_DELAY:
      begin
        next_r.zcnt = r.zcnt + 1'b1;
        if (!set_lvl)
          next_r.zs = ZS_IDLE;
        else if (r.zcnt == CNT_W'(SET_DLY - 1))
        begin
          next_r.offset = (adj - r.preset) & mask;
          next_r.done   = 1'b0;
          next_r.zcnt   = '0;
          next_r.zs     = ZS_BUSY;
        end
      end
      ZS_BUSY:
      begin
        next_r.zcnt = r.zcnt + 1'b1;
        if (r.zcnt == CNT_W'(SET_TMO - 1))
          next_r.done = 1'b1;
        if (r.zcnt == CNT_W'(SET_PROC - 1))
          next_r.zs = ZS_REL;
      end
      ZS_REL:
        if (!set_lvl)
          next_r.zs = ZS_IDLE;
      default: next_r.zs = ZS_IDLE;
    endcase

    // serial link; monoflop counts from the last link edge, rising or falling
    if (pin_rise[PIN_LCLK] || pin_fall[PIN_LCLK])
      next_r.mono = '0;
    else if (r.fr != FR_IDLE)
      next_r.mono = r.mono + 1'b1;
    case (r.fr)
      FR_IDLE:
      begin
        next_r.ser = 1'b1;
        if (pin_fall[PIN_LCLK])
        begin
          // no fresh data while not ready or a zero-set is processing
          if (r.ready && r.zs != ZS_BUSY)
          begin
            next_r.shadow = fresh;
            next_r.len    = fresh_len;
            next_r.shift  = fresh;
            next_r.bits   = fresh_len;
          end
          else
          begin
            next_r.shift = r.shadow;
            next_r.bits  = r.len;
          end
          next_r.fr = FR_SHIFT;
        end
      end
      FR_SHIFT:
      begin
        if (pin_rise[PIN_LCLK])
        begin
          if (r.bits != 5'h00)
          begin
            next_r.ser   = r.shift[31];
            next_r.shift = {r.shift[30:0], 1'b0};
            next_r.bits  = r.bits - 1'b1;
          end
          else
          begin
            next_r.ser = 1'b0;
            next_r.fr  = FR_MONO;
          end
        end
        else if (pin_lvl[PIN_LCLK]
                 && r.mono == CNT_W'(MONO_CYC - 1))
        begin
          next_r.ser = 1'b1;
          next_r.fr  = FR_IDLE;
        end
      end
      FR_MONO:
      begin
        next_r.ser = 1'b0;
        if (pin_fall[PIN_LCLK])
        begin
          next_r.shift = r.shadow;
          next_r.bits  = r.len;
          next_r.fr    = FR_SHIFT;
        end
        else if (r.mono == CNT_W'(MONO_CYC - 1))
        begin
          next_r.ser = 1'b1;
          next_r.fr  = FR_IDLE;
        end
      end
      default: next_r.fr = FR_IDLE;
    endcase

    // pin-facing outputs
    next_r.oe     = 1'b1;
    next_r.rev    = rev_now;
    next_r.led    = next_r.err | (next_r.zs == ZS_BUSY);
    next_r.stat_n = ~next_r.err;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      r        <= '0;
      r.fr     <= FR_IDLE;
      r.zs     <= ZS_IDLE;
      r.res    <= RES_RST;
      r.preset <= PRESET_RST;
      r.ser    <= 1'b1;
      r.oe     <= 1'b1;
      r.stat_n <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign reg_rdata     = r.rdata;
  assign ser_data      = r.ser;
  assign ser_data_oe   = r.oe;
  assign count_reverse = r.rev;
  assign led_on        = r.led;
  assign status_n      = r.stat_n;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_fault_led: assert property (r.err |-> led_on && !status_n)
    else $error("fault without indicator");
  chk_fault_latch: assert property (r.err && !r.biss |=> r.err)
    else $error("fault dropped in SSI mode");
  chk_repeat_same: assert property (
    r.fr == FR_MONO && pin_fall[PIN_LCLK]
    |=> $stable(r.shadow) && r.shift == r.shadow)
    else $error("repeat frame changed data");
  chk_fresh_load: assert property (
    r.fr == FR_IDLE && pin_fall[PIN_LCLK] && r.ready && r.zs != ZS_BUSY
    |=> r.shadow == $past(fresh) && r.fr == FR_SHIFT)
    else $error("new frame not freshly sampled");
  chk_res_legal: assert property (res_ok(r.res))
    else $error("illegal resolution");
  chk_biss_len: assert property (
    r.biss && r.fr == FR_IDLE && pin_fall[PIN_LCLK] && r.ready
    && r.zs != ZS_BUSY |=> r.len == $past(r.res) + BISS_XTRA)
    else $error("BiSS frame length wrong");
  chk_zero_apply: assert property (
    $rose(r.zs == ZS_BUSY) |-> cur == (r.preset & mask))
    else $error("zero-set did not apply preset");
  chk_set_delay: assert property (
    r.zs == ZS_DELAY ##1 r.zs == ZS_BUSY
    |-> $past(r.zcnt) == CNT_W'(SET_DLY - 1))
    else $error("zero-set delay wrong");
  chk_busy_led: assert property (r.zs == ZS_BUSY |-> led_on)
    else $error("indicator off while processing");
  chk_dir_error: assert property (
    r.ready && pin_lvl[PIN_DIR] != r.dir_ref |=> r.err && !status_n)
    else $error("direction change not flagged");
  chk_msb_first: assert property (
    r.fr == FR_SHIFT && pin_rise[PIN_LCLK] && r.bits != 5'h00
    |=> ser_data == $past(r.shift[31]))
    else $error("serial bit order wrong");
  chk_hold_frame: assert property (
    r.fr != FR_IDLE ##1 r.fr != FR_IDLE |-> $stable(r.shadow))
    else $error("latched word changed mid frame");

endmodule // aessc_ctrl

// ---- aessc_pkg.sv ----
// shared constants and carrier types of the encoder control block
package aessc_pkg;

  localparam int CLK_KHZ = 100_000;

  // link monoflop, longest time, rounds down
  localparam int MONO_NS  = 15_000;
  localparam int MONO_CYC = MONO_NS * CLK_KHZ / 1_000_000;

  // zero-set and power-on timing, in milliseconds
  localparam int SET_DLY_MS  = 1;
  localparam int SET_TMO_MS  = 14;
  localparam int SET_PROC_MS = 15;
  localparam int PWR_ON_MS   = 150;
  localparam int SET_DLY_CYC  = SET_DLY_MS * CLK_KHZ;
  localparam int SET_TMO_CYC  = SET_TMO_MS * CLK_KHZ;
  localparam int SET_PROC_CYC = SET_PROC_MS * CLK_KHZ;
  localparam int PWR_ON_CYC   = PWR_ON_MS * CLK_KHZ;

  localparam int CNT_W = 24;
  localparam int POS_W = 17;

  // register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_PRESET = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;

  // control field positions
  localparam int CTRL_BISS    = 0;
  localparam int CTRL_GRAY    = 1;
  localparam int CTRL_DIRINV  = 2;
  localparam int CTRL_ERRCLR  = 3;
  localparam int CTRL_RES_LSB = 8;

  // status field positions
  localparam int ST_ERR    = 0;
  localparam int ST_READY  = 1;
  localparam int ST_BUSY   = 2;
  localparam int ST_DONE   = 3;
  localparam int ST_REV    = 4;
  localparam int ST_FRAME  = 5;

  // values after reset
  localparam logic [4:0]       RES_RST    = 5'h11;
  localparam logic [POS_W-1:0] PRESET_RST = 17'h00000;

  // frame layout
  localparam logic [5:0] CRC_POLY  = 6'h03;
  localparam logic [4:0] BISS_XTRA = 5'h0A;

  // pin slots of the input synchroniser bank
  localparam int PIN_LCLK = 0;
  localparam int PIN_SET  = 1;
  localparam int PIN_BTN  = 2;
  localparam int PIN_DIR  = 3;
  localparam int PIN_N    = 4;
  localparam logic [PIN_N-1:0] PIN_RST_LVL = 4'h1;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } aessc_reg_req_t;

  typedef struct packed {
    logic sensor;
    logic led;
    logic temp;
  } aessc_fault_t;

  typedef enum logic [1:0] {
    FR_IDLE  = 2'b00,
    FR_SHIFT = 2'b01,
    FR_MONO  = 2'b10
  } aessc_frame_t;

  typedef enum logic [1:0] {
    ZS_IDLE  = 2'b00,
    ZS_DELAY = 2'b01,
    ZS_BUSY  = 2'b10,
    ZS_REL   = 2'b11
  } aessc_zs_t;

endpackage

// ---- aessc_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter and edge pulses
module aessc_pin_sync #(
  parameter logic RST_LVL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import aessc_pkg::*;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic lvl;
    logic rise;
    logic fall;
  } aessc_sync_t;

  aessc_sync_t r;
  aessc_sync_t next_r;

  always_comb
  begin
    next_r      = r;
    next_r.ff1  = pin;
    next_r.ff2  = r.ff1;
    next_r.ff3  = r.ff2;
    next_r.rise = 1'b0;
    next_r.fall = 1'b0;
    // a change counts once stages two and three agree
    if (r.ff2 == r.ff3)
    begin
      next_r.lvl  = r.ff3;
      next_r.rise = r.ff3 & ~r.lvl;
      next_r.fall = ~r.ff3 & r.lvl;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      r <= '{ff1: RST_LVL, ff2: RST_LVL, ff3: RST_LVL, lvl: RST_LVL,
             rise: 1'b0, fall: 1'b0};
    else
      r <= next_r;
  end

  assign level = r.lvl;
  assign rise  = r.rise;
  assign fall  = r.fall;

endmodule // aessc_pin_sync

// ---- aessc_ssi_master.sv ----
// link master model: makes the serial clock and gathers the data bits
module aessc_ssi_master (
  output logic      link_clk,
  input  wire logic ser_data
);
  timeunit 1ns;
  timeprecision 100ps;

  initial link_clk = 1'b1;

  // n+1 clock periods, one bit taken just before each later falling edge
  task automatic frame(input int n, output logic [31:0] word);
    word = 32'h0;
    #3.3;
    for (int i = 0; i <= n; i++)
    begin
      if (i > 0)
        word = {word[30:0], ser_data};
      link_clk = 1'b0;
      #80;
      link_clk = 1'b1;
      #80;
    end
  endtask
endmodule // aessc_ssi_master

// ---- aessc_ctrl_test.sv ----
// self-checking bench of the encoder control block
module aessc_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  import aessc_pkg::*;

  localparam logic [16:0] P1 = 17'h1A5C3;
  localparam logic [16:0] P2 = 17'h0B3E6;

  logic           core_clk = 1'b0;
  logic           rst = 1'b1;
  aessc_reg_req_t reg_req = '0;
  logic [31:0]    reg_rdata;
  logic [16:0]    position_in = 17'h00000;
  aessc_fault_t   fault_in = '0;
  logic           link_clk;
  logic           ser_data;
  logic           ser_data_oe;
  logic           zero_set_pin = 1'b0;
  logic           zero_set_btn = 1'b0;
  logic           dir_pin = 1'b0;
  logic           count_reverse;
  logic           led_on;
  logic           status_n;
  logic [31:0]    w;
  int             fails = 0;
  int             num_checks = 0;

  always #5 core_clk = ~core_clk;

  aessc_ctrl #(
    .SET_DLY  (20),
    .SET_TMO  (280),
    .SET_PROC (300),
    .PWR_ON   (50)
  ) dut (
    .core_clk      (core_clk),
    .rst           (rst),
    .reg_req       (reg_req),
    .reg_rdata     (reg_rdata),
    .position_in   (position_in),
    .fault_in      (fault_in),
    .link_clk      (link_clk),
    .ser_data      (ser_data),
    .ser_data_oe   (ser_data_oe),
    .zero_set_pin  (zero_set_pin),
    .zero_set_btn  (zero_set_btn),
    .dir_pin       (dir_pin),
    .count_reverse (count_reverse),
    .led_on        (led_on),
    .status_n      (status_n)
  );

  aessc_ssi_master link_master (
    .link_clk (link_clk),
    .ser_data (ser_data)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask

  // fresh waits out the monoflop first
  task automatic frame(input int n, input logic [31:0] exp, input bit fresh);
    logic [31:0] got;
    if (fresh)
      cyc(1600);
    link_master.frame(n, got);
    chk(got, exp);
  endtask

  // reference crc over position, error and warning bits, msb first
  function automatic logic [5:0] crc_ref(input logic [18:0] d);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 18; i >= 0; i--)
      c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? CRC_POLY : 6'h00);
    crc_ref = c;
  endfunction

  task automatic test_done;
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    cyc(6);
    rst <= 1'b0;
    cyc(1);
    @(negedge core_clk);
    chk(32'({ser_data, ser_data_oe, count_reverse, led_on, status_n}),
        32'h19);
    rd(REG_CTRL, 32'h0000_1100);
    rd(8'h0C, 32'h0);
    cyc(60);
    rd(REG_STATUS, 32'h0000_0002);
    @(posedge core_clk);
    position_in <= P1;
    frame(17, 32'(P1), 1'b1);
    chk(32'(ser_data), 32'h0);
    @(posedge core_clk);
    position_in <= P2;
    frame(17, 32'(P1), 1'b0);
    cyc(1600);
    chk(32'(ser_data), 32'h1);
    frame(17, 32'(P2), 1'b0);
    // resolution 12 with gray code, then an illegal width that is ignored
    wr(REG_CTRL, 32'h0000_0C02);
    wr(REG_CTRL, 32'h0000_0F02);
    rd(REG_CTRL, 32'h0000_0C02);
    frame(12, 32'(P2[11:0] ^ (P2[11:0] >> 1)), 1'b1);
    // factory inversion of the count sense
    wr(REG_CTRL, 32'h0000_1104);
    cyc(2);
    chk(32'(count_reverse), 32'h1);
    frame(17, 32'(17'h1FFFF - P2), 1'b1);
    // bidirectional mode: start bits then the position word
    wr(REG_CTRL, 32'h0000_1101);
    cyc(1600);
    link_master.frame(27, w);
    chk(32'(w[26:8]), 32'({2'b10, P2}));
    chk(32'(w[7:0]), {24'h0, 2'b11, ~crc_ref({P2, 2'b11})});
    // every fault source, cleared by the write-one bit in this mode
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      if (k < 3)
        fault_in <= 3'b100 >> k;
      else
        dir_pin <= 1'b1;
      cyc(100);
      chk(32'({led_on, status_n, count_reverse}),
          32'({2'b10, k == 3}));
      fault_in <= 3'b000;
      dir_pin <= 1'b0;
      cyc(100);
      chk(32'({led_on, status_n}), 32'h2);
      wr(REG_CTRL, 32'h0000_1109);
      cyc(3);
      chk(32'({led_on, status_n}), 32'h1);
    end
    // zero-set by the input pin, back in the plain link mode
    wr(REG_CTRL, 32'h0000_1100);
    // let the monoflop run out so no frame shows in status
    cyc(1600);
    @(posedge core_clk);
    zero_set_pin <= 1'b1;
    cyc(8);
    rd(REG_STATUS, 32'h0000_0002);
    cyc(50);
    rd(REG_STATUS, 32'h0000_0006);
    chk(32'(led_on), 32'h1);
    cyc(40);
    zero_set_pin <= 1'b0;
    cyc(300);
    rd(REG_STATUS, 32'h0000_000A);
    chk(32'(led_on), 32'h0);
    frame(17, 32'h0, 1'b1);
    // zero-set by the button onto a preset value
    wr(REG_PRESET, 32'h0000_0123);
    @(posedge core_clk);
    zero_set_btn <= 1'b1;
    cyc(100);
    zero_set_btn <= 1'b0;
    cyc(300);
    frame(17, 32'h0000_0123, 1'b1);
    // a fault here survives the clear bit and a zero-set
    @(posedge core_clk);
    fault_in <= 3'b001;
    cyc(5);
    fault_in <= 3'b000;
    wr(REG_CTRL, 32'h0000_1108);
    @(posedge core_clk);
    zero_set_pin <= 1'b1;
    cyc(100);
    zero_set_pin <= 1'b0;
    cyc(400);
    chk(32'({led_on, status_n}), 32'h2);
    test_done;
  end

  initial
  begin
    #400us;
    fails++;
    test_done;
  end
endmodule // aessc_ctrl_test
